// [hsrp_pkg.sv]
// hsrp_pkg: constants and carrier types for the handler sort result port
// assumes: one 100 MHz clock; no software registers; no import used
//
// Behaviour
// - nine bin outputs; drive low the one matching the sorted bin.
// - secondary-over output low on secondary fail, only when aux is on.
// - primary-over output active low, level is OR of high and low fail.
// - primary-high-fail output low when primary exceeds its upper limit.
// - primary-low-fail output low when primary falls below lower limit.
// - overall reject active low, level is OR of secondary and primary over.
// - conversion index held low during conversion, high once finished.
// - measure done held low while a test runs, high when it finishes.
// - a rising edge on the external trigger starts a measurement when idle; edges during a test are dropped.
// - keypad locked while keypad lock input low, unlocked while high.
`default_nettype none
package hsrp_pkg;

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int unsigned NUM_BINS   = 9;
  localparam logic [3:0]  BIN_NONE   = 4'h0; // bin code 0 means no bin
  localparam logic [8:0]  BIN_IDLE_N = 9'h1FF; // all bins released high
  localparam logic [1:0]  SYNC_RST   = 2'h0;
  localparam logic [1:0]  LOCK_SYNC_RST = 2'h3; // lock pin idles high

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    HSRP_IDLE    = 3'b000,
    HSRP_CONVERT = 3'b001,
    HSRP_MATH    = 3'b010,
    HSRP_PUBLISH = 3'b011,
    HSRP_FINISH  = 3'b100
  } hsrp_state_t;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  // result from the comparator, valid with result_valid
  typedef struct packed {
    logic [3:0] bin;        // 1..9, 0 = no bin
    logic       pri_high;   // primary above upper limit
    logic       pri_low;    // primary below lower limit
    logic       sec_over;   // secondary over limits
  } hsrp_result_t;

  // handler outputs, all active low
  typedef struct packed {
    logic [8:0] bin_n;
    logic       sec_over_n;
    logic       pri_over_n;
    logic       primary_high_fail_n;
    logic       primary_low_fail_n;
    logic       overall_reject_n;
    logic       conv_index;
    logic       measure_done;
  } hsrp_pins_t;

  // every handler pin released high out of reset except the bin 9 output bin_n[8], which the 15-bit value leaves low
  localparam hsrp_pins_t PINS_RST = 15'h7FFF;

endpackage : hsrp_pkg

`default_nettype wire

// [hsrp_port.sv]
// hsrp_port: handler sort result port sequencer and output drivers
// assumes: measurement core answers meas_start_o with conv_done_i and later
// result_valid_i; handler pins are isolated externally
`timescale 1ns/1ps
`default_nettype none

module hsrp_port (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   ext_trigger_in_i,
  input  wire logic                   keypad_lock_n_i,
  input  wire logic                   aux_enable_i,
  input  wire logic                   conv_done_i,
  input  wire logic                   result_valid_i,
  input  wire hsrp_pkg::hsrp_result_t result_i,
  output logic                        meas_start_o,
  output logic                        keypad_locked_o,
  output var hsrp_pkg::hsrp_pins_t    pins_o
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [1:0] trig_sync_q;
  logic [1:0] trig_sync_d;
  logic [1:0] lock_sync_q;
  logic [1:0] lock_sync_d;
  logic       trig_prev_q;
  logic       trig_prev_d;
  logic       trig_rise;

  // two flops per pin input, then edge detect on the second
  always_comb begin
    trig_sync_d = {trig_sync_q[0], ext_trigger_in_i};
    lock_sync_d = {lock_sync_q[0], keypad_lock_n_i};
    trig_prev_d = trig_sync_q[1];
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_sync_q <= hsrp_pkg::SYNC_RST;
      lock_sync_q <= hsrp_pkg::LOCK_SYNC_RST;
      trig_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= trig_sync_d;
      lock_sync_q <= lock_sync_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  assign trig_rise = trig_sync_q[1] & ~trig_prev_q;

  // keypad lock follows the synchronised level
  assign keypad_locked_o = ~lock_sync_q[1];

  // ****************************************************************
  // measurement sequencer
  // ****************************************************************
  hsrp_pkg::hsrp_state_t state_q;
  hsrp_pkg::hsrp_state_t state_d;
  hsrp_pkg::hsrp_result_t res_q;
  hsrp_pkg::hsrp_result_t res_d;

  always_comb begin
    state_d      = state_q;
    res_d        = res_q;
    meas_start_o = 1'b0;
    unique case (state_q)
      hsrp_pkg::HSRP_IDLE: begin
        if (trig_rise) begin
          meas_start_o = 1'b1;
          state_d      = hsrp_pkg::HSRP_CONVERT;
        end
      end
      // trigger edges here and below are dropped
      hsrp_pkg::HSRP_CONVERT: begin
        if (conv_done_i) begin
          state_d = hsrp_pkg::HSRP_MATH;
        end
      end
      hsrp_pkg::HSRP_MATH: begin
        if (result_valid_i) begin
          res_d   = result_i;
          state_d = hsrp_pkg::HSRP_PUBLISH;
        end
      end
      hsrp_pkg::HSRP_PUBLISH: begin
        state_d = hsrp_pkg::HSRP_FINISH;
      end
      hsrp_pkg::HSRP_FINISH: begin
        state_d = hsrp_pkg::HSRP_IDLE;
      end
      default: begin
        state_d = hsrp_pkg::HSRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= hsrp_pkg::HSRP_IDLE;
      res_q   <= '0;
    end else begin
      state_q <= state_d;
      res_q   <= res_d;
    end
  end

  // ****************************************************************
  // output pin registers
  // ****************************************************************
  hsrp_pkg::hsrp_pins_t pins_q;
  hsrp_pkg::hsrp_pins_t pins_d;
  logic                 sec_fail;
  logic                 pri_over;

  // one-hot active-low bin decode
  function automatic logic [8:0] bin_decode_n(input logic [3:0] bin);
    logic [8:0] v;
    v = hsrp_pkg::BIN_IDLE_N;
    for (int i = 0; i < hsrp_pkg::NUM_BINS; i++) begin
      if (bin == 4'(i + 1)) begin
        v[i] = 1'b0;
      end
    end
    return v;
  endfunction

  assign sec_fail = res_q.sec_over & aux_enable_i;
  assign pri_over = res_q.pri_high | res_q.pri_low;

  always_comb begin
    pins_d = pins_q;
    // conversion index low only while converting
    pins_d.conv_index = (state_d != hsrp_pkg::HSRP_CONVERT);
    // test in progress from trigger until back in idle, so done rises
    // one cycle after the results land and the handler samples settled pins
    pins_d.measure_done = (state_d == hsrp_pkg::HSRP_IDLE);
    if (state_q == hsrp_pkg::HSRP_PUBLISH) begin
      pins_d.bin_n               = bin_decode_n(res_q.bin);
      pins_d.sec_over_n          = ~sec_fail;
      pins_d.pri_over_n          = ~pri_over;
      pins_d.primary_high_fail_n = ~res_q.pri_high;
      pins_d.primary_low_fail_n  = ~res_q.pri_low;
      pins_d.overall_reject_n    = ~(sec_fail | pri_over);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_q <= hsrp_pkg::PINS_RST;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pins_o = pins_q;

endmodule // hsrp_port

`default_nettype wire

// [hsrp_port_checker.sv]
// hsrp_port_checker: timing and level checks on the handler port
// assumes: bound onto hsrp_port; one clock domain
`timescale 1ns/1ps
`default_nettype none
module hsrp_port_checker (
  input wire logic                 mclk_i,
  input wire logic                 rst_b_i,
  input wire logic                 keypad_lock_n_i,
  input wire logic                 aux_enable_i,
  input wire logic                 conv_done_i,
  input wire logic                 meas_start_o,
  input wire logic                 keypad_locked_o,
  input wire hsrp_pkg::hsrp_pins_t pins_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // both busy flags low together
  sequence s_busy;
    !pins_o.conv_index && !pins_o.measure_done;
  endsequence
  // done still low, then released on the following cycle
  sequence s_done_after;
    !pins_o.measure_done ##1 pins_o.measure_done;
  endsequence
  // start, combined fail levels, bin and busy relations
  a_start_busy: assert property (meas_start_o |=> s_busy)
    else $error("busy flags not low after start");
  a_pri_over: assert property (pins_o.pri_over_n ==
    (pins_o.primary_high_fail_n & pins_o.primary_low_fail_n))
    else $error("primary over level wrong");
  a_reject_or: assert property (pins_o.overall_reject_n ==
    (pins_o.sec_over_n & pins_o.pri_over_n))
    else $error("reject level wrong");
  a_one_bin: assert property ($countones(~pins_o.bin_n) <= 1)
    else $error("more than one bin low");
  a_bins_done: assert property ($changed(pins_o.bin_n) |->
    s_done_after) else $error("bins moved off done");
  a_index_rel: assert property (!pins_o.conv_index && conv_done_i |=>
    pins_o.conv_index) else $error("conversion index not released");
  a_busy_start: assert property (!pins_o.measure_done |->
    !meas_start_o) else $error("start while busy");
  a_aux_mask: assert property ($rose(pins_o.measure_done) &&
    !aux_enable_i |-> pins_o.sec_over_n) else $error("aux mask");
  a_lock_in: assert property ($fell(keypad_lock_n_i) |->
    ##[1:3] keypad_locked_o) else $error("keypad not locked");
endmodule // hsrp_port_checker
`default_nettype wire

// [hsrp_core_model.sv]
// hsrp_core_model: measurement core answering each start
// assumes: conversion done 5 cycles, result 8 cycles after start
`timescale 1ns/1ps
`default_nettype none
module hsrp_core_model (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   start_i,
  input  wire hsrp_pkg::hsrp_result_t res_i,
  output logic                        conv_done_o,
  output logic                        result_valid_o,
  output var hsrp_pkg::hsrp_result_t  result_o
);
  int cnt_q;
  // step counter from the start pulse
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_q <= 0;
    else if (start_i) cnt_q <= 1;
    else if (cnt_q != 0) cnt_q <= (cnt_q == 8) ? 0 : cnt_q + 1;
  end
  // stale result lines inverted so nothing stale is trusted
  assign conv_done_o    = (cnt_q == 5);
  assign result_valid_o = (cnt_q == 8);
  assign result_o       = result_valid_o ? res_i : ~res_i;
endmodule // hsrp_core_model
`default_nettype wire

// [hsrp_port_tb_top.sv]
// hsrp_port_tb_top: self-checking bench for the handler port
// assumes: core model answers every start; 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module hsrp_port_tb_top;
  logic mclk_i = 0, rst_b_i = 0, trig = 0, kl_n = 1, aux = 0;
  logic start, cdone, rval, lck;
  hsrp_pkg::hsrp_result_t res = '0, cres;
  hsrp_pkg::hsrp_pins_t   pins;
  int miscompares = 0, n_checks = 0, cyc = 0, starts = 0, exp_st = 0;
  always #5 mclk_i = ~mclk_i;
  hsrp_port u_hsrp_port (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ext_trigger_in_i(trig), .keypad_lock_n_i(kl_n), .aux_enable_i(aux),
    .conv_done_i(cdone), .result_valid_i(rval), .result_i(cres),
    .meas_start_o(start), .keypad_locked_o(lck), .pins_o(pins));
  hsrp_core_model u_hsrp_core_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .start_i(start), .res_i(res), .conv_done_o(cdone),
    .result_valid_o(rval), .result_o(cres));
  // counts start pulses and cuts a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (start) starts++;
    if (cyc == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [14:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // trigger once, optionally re-trigger while busy, then judge pins
  task automatic meas(input logic [3:0] b, input logic [2:0] f,
                      input logic a, input logic rt);
    hsrp_pkg::hsrp_pins_t e;
    @(posedge mclk_i);
    res <= {b, f};
    aux <= a;
    trig <= 1;
    for (int n = 0; n < 40 && !(n > 4 && pins.measure_done); n++) begin
      @(posedge mclk_i);
      if (rt && n == 2) trig <= 0;
      if (rt && n == 4) trig <= 1;
      #1;
      if (n == 3) chk("index", 15'h0000, 15'(pins.conv_index));
      if (n == 3) chk("done", 15'h0000, 15'(pins.measure_done));
      if (n == 9) chk("index", 15'h0001, 15'(pins.conv_index));
    end
    e = '1;
    if (b >= 1 && b <= 9) e.bin_n[b-1] = 0;
    e.primary_high_fail_n = !f[2];
    e.primary_low_fail_n = !f[1];
    e.sec_over_n = !(f[0] && a);
    e.pri_over_n = !(f[2] || f[1]);
    e.overall_reject_n = e.sec_over_n & e.pri_over_n;
    exp_st++;
    chk("pins", e, pins);
    chk("starts", 15'(exp_st), 15'(starts));
    @(posedge mclk_i);
    trig <= 0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge mclk_i);
    for (int i = 1; i <= 9; i++) meas(4'(i), 3'h0, 1, 0);
    meas(4'hA, 3'h0, 0, 0);
    meas(4'h0, 3'h4, 0, 0);
    meas(4'h3, 3'h2, 0, 1);
    meas(4'h0, 3'h1, 1, 0);
    meas(4'h2, 3'h1, 0, 0);
    meas(4'h0, 3'h7, 1, 0);
    kl_n <= 0;
    repeat (4) @(posedge mclk_i);
    #1 chk("locked", 15'h0001, 15'(lck));
    @(posedge mclk_i);
    kl_n <= 1;
    repeat (4) @(posedge mclk_i);
    #1 chk("unlocked", 15'h0000, 15'(lck));
    finish_test();
  end
endmodule // hsrp_port_tb_top
bind hsrp_port hsrp_port_checker u_chk (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .keypad_lock_n_i(keypad_lock_n_i),
  .aux_enable_i(aux_enable_i), .conv_done_i(conv_done_i),
  .meas_start_o(meas_start_o),
  .keypad_locked_o(keypad_locked_o), .pins_o(pins_o));
`default_nettype wire
